// ### verilog/mqe_config.sv
// Strap capture, queue address decode, status ring and read bus control.
`timescale 1ns/1ps
`include "mqe_regs.svh"

module mqe_config #(
  parameter int ADDR_W = `MQE_ADDR_W,
  parameter int QUADS  = `MQE_QUADS,
  parameter int QUAD_W = `MQE_QUAD_W,
  parameter int DATA_W = `MQE_DATA_W
) (
  input  wire logic                    ref_clk,
  input  wire logic                    rst_n,
  input  wire logic [2:0]              device_select_code,
  input  wire logic                    input_width_strap,
  input  wire logic                    primary_role_strap,
  input  wire logic                    poll_mode_strap,
  input  wire logic                    flag_chain_token_in,
  output logic                         flag_chain_token_out,
  input  wire logic [QUADS*QUAD_W-1:0] quad_status_flags,
  output logic [QUAD_W-1:0]            almost_full_status_bus,
  output logic                         almost_full_status_bus_oe,
  output logic                         status_bus_sync,
  input  wire logic [ADDR_W-1:0]       write_queue_address,
  input  wire logic                    write_address_en,
  output logic                         write_select,
  output logic [4:0]                   write_queue_index,
  input  wire logic [ADDR_W-1:0]       read_queue_address,
  input  wire logic                    read_address_en,
  input  wire logic                    null_queue_select,
  output logic                         read_select,
  output logic                         read_null_select,
  output logic [4:0]                   read_queue_index,
  input  wire logic                    output_enable_n,
  input  wire logic [DATA_W-1:0]       read_data_in,
  output logic [DATA_W-1:0]            read_data_out,
  output logic                         read_data_oe,
  output logic                         input_is_9bit,
  output logic                         is_primary,
  output logic                         poll_mode
);

  // ****************************************************************
  // Elaboration checks
  // ****************************************************************
  if (ADDR_W != `MQE_DEV_BITS + `MQE_QUEUE_BITS || QUADS != 4 || QUAD_W < 1) begin : g_bad
    $error("mqe_config supports an 8-bit address and four quadrants only.");
  end

  // ****************************************************************
  // Strap capture
  // ****************************************************************
  logic [`MQE_STRAP_W-1:0] strap_sync;
  logic [2:0]              id_q, id_d;
  logic                    iw_q, iw_d, pri_q, pri_d, poll_q, poll_d;

  mqe_sync2 #(.WIDTH(`MQE_STRAP_W)) u_strap_sync (
    .ref_clk  (ref_clk),
    .async_in ({poll_mode_strap, primary_role_strap, input_width_strap, device_select_code}),
    .sync_out (strap_sync)
  );

  // Straps follow the synchroniser while reset is low and freeze at release.
  always_comb begin
    id_d   = id_q;
    iw_d   = iw_q;
    pri_d  = pri_q;
    poll_d = poll_q;
    if (!rst_n) begin
      id_d   = strap_sync[`MQE_STRAP_ID_LSB +: 3];
      iw_d   = strap_sync[`MQE_STRAP_IW];
      pri_d  = strap_sync[`MQE_STRAP_PRI];
      poll_d = strap_sync[`MQE_STRAP_POLL];
    end
  end

  // Strap registers.
  always_ff @(posedge ref_clk) begin
    id_q   <= id_d;
    iw_q   <= iw_d;
    pri_q  <= pri_d;
    poll_q <= poll_d;
  end

  assign input_is_9bit = iw_q;
  assign is_primary    = pri_q;
  assign poll_mode     = poll_q;

  // ****************************************************************
  // Queue address decode
  // ****************************************************************
  logic       wr_hit, rd_hit;
  logic       wsel_q, wsel_d, rsel_q, rsel_d, rnull_q, rnull_d, owned_q, owned_d;
  logic [4:0] widx_q, widx_d, ridx_q, ridx_d;

  // Any identity value is compared the same way, whatever the chain order.
  assign wr_hit = write_address_en &&
                  write_queue_address[`MQE_DEV_MSB:`MQE_DEV_LSB] == id_q;
  assign rd_hit = read_address_en &&
                  read_queue_address[`MQE_DEV_MSB:`MQE_DEV_LSB] == id_q;

  // Selections give one-cycle pulses; read ownership follows the last read selection.
  always_comb begin
    wsel_d  = wr_hit;
    rsel_d  = rd_hit && !null_queue_select;
    rnull_d = rd_hit && null_queue_select;
    widx_d  = wr_hit ? write_queue_address[`MQE_QUEUE_BITS-1:0] : widx_q;
    ridx_d  = rd_hit ? read_queue_address[`MQE_QUEUE_BITS-1:0] : ridx_q;
    owned_d = read_address_en ? rd_hit : owned_q;
    if (!rst_n) begin
      wsel_d  = 1'b0;
      rsel_d  = 1'b0;
      rnull_d = 1'b0;
      widx_d  = 5'h00;
      ridx_d  = 5'h00;
      owned_d = 1'b0;
    end
  end

  // Decode registers.
  always_ff @(posedge ref_clk) begin
    wsel_q  <= wsel_d;
    rsel_q  <= rsel_d;
    rnull_q <= rnull_d;
    widx_q  <= widx_d;
    ridx_q  <= ridx_d;
    owned_q <= owned_d;
  end

  assign write_select      = wsel_q;
  assign write_queue_index = widx_q;
  assign read_select       = rsel_q;
  assign read_null_select  = rnull_q;
  assign read_queue_index  = ridx_q;

  // ****************************************************************
  // Polled status quadrant ring
  // ****************************************************************
  mqe_pkg::mqe_poll_e state_q, state_d;
  logic               start_q, start_d;
  logic [QUAD_W-1:0]  bus_q, bus_d;

  // The master opens the ring after reset; others wait for the token.
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    bus_d   = bus_q;
    case (state_q)
      mqe_pkg::MQE_IDLE: begin
        if (poll_q && (flag_chain_token_in || (start_q && pri_q))) begin
          state_d = mqe_pkg::MQE_Q1;
        end
      end
      mqe_pkg::MQE_Q1: state_d = mqe_pkg::MQE_Q2;
      mqe_pkg::MQE_Q2: state_d = mqe_pkg::MQE_Q3;
      mqe_pkg::MQE_Q3: state_d = mqe_pkg::MQE_Q4;
      mqe_pkg::MQE_Q4: begin
        state_d = flag_chain_token_in ? mqe_pkg::MQE_Q1 : mqe_pkg::MQE_IDLE;
      end
      default: state_d = mqe_pkg::MQE_IDLE;
    endcase
    case (state_d)
      mqe_pkg::MQE_Q1: bus_d = quad_status_flags[0*QUAD_W +: QUAD_W];
      mqe_pkg::MQE_Q2: bus_d = quad_status_flags[1*QUAD_W +: QUAD_W];
      mqe_pkg::MQE_Q3: bus_d = quad_status_flags[2*QUAD_W +: QUAD_W];
      mqe_pkg::MQE_Q4: bus_d = quad_status_flags[3*QUAD_W +: QUAD_W];
      default:         bus_d = bus_q;
    endcase
    if (!rst_n) begin
      state_d = mqe_pkg::MQE_IDLE;
      start_d = 1'b1;
      bus_d   = '0;
    end
  end

  // Ring registers.
  always_ff @(posedge ref_clk) begin
    state_q <= state_d;
    start_q <= start_d;
    bus_q   <= bus_d;
  end

  // Only the device holding the token drives the shared status bus.
  assign almost_full_status_bus    = bus_q;
  assign almost_full_status_bus_oe = state_q != mqe_pkg::MQE_IDLE;
  assign status_bus_sync           = state_q == mqe_pkg::MQE_Q1;
  assign flag_chain_token_out      = state_q == mqe_pkg::MQE_Q4;

  // ****************************************************************
  // Read data bus three-state control
  // ****************************************************************
  logic [DATA_W-1:0] rdata_q, rdata_d;

  // Read data are registered every cycle.
  always_comb begin
    rdata_d = rst_n ? read_data_in : '0;
  end

  // Read data register.
  always_ff @(posedge ref_clk) begin
    rdata_q <= rdata_d;
  end

  // The enable path is combinational from the pin, so it needs no clock.
  assign read_data_out = rdata_q;
  assign read_data_oe  = (pri_q || owned_q) && !output_enable_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence quad_walk_s;
    state_q == mqe_pkg::MQE_Q2 ##1 state_q == mqe_pkg::MQE_Q3 ##1 state_q == mqe_pkg::MQE_Q4;
  endsequence

  token_pulse_a: assert property (state_q == mqe_pkg::MQE_Q4 |-> flag_chain_token_out &&
      almost_full_status_bus == $past(quad_status_flags[3*QUAD_W +: QUAD_W]))
    else $error("Token not pulsed with the fourth quadrant.");
  token_load_a: assert property (state_q == mqe_pkg::MQE_IDLE && flag_chain_token_in &&
      poll_q |=> status_bus_sync && almost_full_status_bus_oe)
    else $error("First quadrant not loaded after token.");
  quad_walk_a: assert property (status_bus_sync |=> quad_walk_s ##1
      (!status_bus_sync || $past(flag_chain_token_in)))
    else $error("Quadrant order broken.");
  write_match_a: assert property (wr_hit |=> write_select &&
      write_queue_index == $past(write_queue_address[4:0]))
    else $error("Matching write selection not taken.");
  write_miss_a: assert property (!wr_hit |=> !write_select)
    else $error("Write selection taken for another device.");
  null_queue_a: assert property (rd_hit && null_queue_select |=> read_null_select &&
      !read_select)
    else $error("Null queue not selected.");
  id_hold_a: assert property ($past(rst_n) |-> $stable(id_q) && $stable(pri_q))
    else $error("Straps changed after reset.");
  slave_off_a: assert property (!pri_q && !owned_q |-> !read_data_oe)
    else $error("Unselected slave drives the read bus.");
  master_oe_a: assert property (pri_q |-> read_data_oe == !output_enable_n)
    else $error("Master read bus does not follow output enable.");
  master_first_a: assert property ($rose(rst_n) && poll_q && pri_q |=> status_bus_sync)
    else $error("Master did not open the ring after reset.");

endmodule : mqe_config

// ### verilog/mqe_regs.svh
// Constants for the multi-queue expansion and configuration block.
`ifndef MQE_REGS_SVH
`define MQE_REGS_SVH

// ****************************************************************
// Address layout
// ****************************************************************
`define MQE_ADDR_W      8
`define MQE_DEV_BITS    3
`define MQE_QUEUE_BITS  5
`define MQE_DEV_MSB     7
`define MQE_DEV_LSB     5

// ****************************************************************
// Status bus layout
// ****************************************************************
`define MQE_QUADS       4
`define MQE_QUAD_W      8

// ****************************************************************
// Data and strap layout
// ****************************************************************
`define MQE_DATA_W      18
`define MQE_STRAP_W     6
`define MQE_STRAP_ID_LSB 0
`define MQE_STRAP_IW    3
`define MQE_STRAP_PRI   4
`define MQE_STRAP_POLL  5
`define MQE_ID_RST      3'h0

`endif

// ### verilog/mqe_pkg.sv
// Types shared by the multi-queue expansion and configuration block.
package mqe_pkg;

  // One-hot states of the polled status quadrant sequencer.
  typedef enum logic [4:0] {
    MQE_IDLE = 5'h01,
    MQE_Q1   = 5'h02,
    MQE_Q2   = 5'h04,
    MQE_Q3   = 5'h08,
    MQE_Q4   = 5'h10
  } mqe_poll_e;

endpackage : mqe_pkg

// ### verilog/mqe_sync2.sv
// Two flip-flop synchroniser for asynchronous strap levels.
`timescale 1ns/1ps

module mqe_sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             ref_clk,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  // ****************************************************************
  // Elaboration check
  // ****************************************************************
  if (WIDTH < 1) begin : g_bad_width
    $error("mqe_sync2 needs a width of at least one bit.");
  end

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;

  // Only the second stage reads the first stage. There is no reset, so the straps
  // reach the capture registers while full reset is held low.
  always_comb begin
    meta_d = async_in;
    sync_d = meta_q;
  end

  // Both stages register on every rising edge.
  always_ff @(posedge ref_clk) begin
    meta_q <= meta_d;
    sync_q <= sync_d;
  end

  assign sync_out = sync_q;

endmodule : mqe_sync2

// ### dv/mqe_ring_peer.sv
// Ring peer that hands the status token back to the device after a delay.
`timescale 1ns/1ps

module mqe_ring_peer #(
  parameter int DELAY = 3
) (
  input  wire logic ref_clk,
  input  wire logic rst_n,
  input  wire logic token_from_dev,
  output logic      token_to_dev
);
  // ****************************************************************
  // Token path
  // ****************************************************************
  logic [DELAY-1:0] hops_q;

  // The other devices of the ring hold the token DELAY cycles, then pass it on.
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      hops_q <= '0;
    end else begin
      hops_q <= (hops_q << 1) | DELAY'(token_from_dev);
    end
  end

  // The last hop feeds the device's token input.
  assign token_to_dev = hops_q[DELAY-1];
endmodule : mqe_ring_peer

// ### dv/test_mqe_config.sv
// Self-checking testbench for the expansion and configuration block.
`timescale 1ns/1ps

module test_mqe_config;
  // ****************************************************************
  // Signals, design and ring peer
  // ****************************************************************
  localparam logic [31:0] FLAGS = 32'h44332211;
  logic        ref_clk, rst_n, input_width_strap, primary_role_strap, poll_mode_strap;
  logic        flag_chain_token_in, flag_chain_token_out, almost_full_status_bus_oe;
  logic        status_bus_sync, write_address_en, write_select, read_address_en;
  logic        null_queue_select, read_select, read_null_select, output_enable_n;
  logic        read_data_oe, input_is_9bit, is_primary, poll_mode, self_loop, peer_token;
  logic [2:0]  device_select_code;
  logic [4:0]  write_queue_index, read_queue_index;
  logic [7:0]  almost_full_status_bus, write_queue_address, read_queue_address;
  logic [17:0] read_data_in, read_data_out;
  logic [31:0] quad_status_flags;
  int          errors, n_compared, cycles;

  mqe_config dut (
    .ref_clk, .rst_n, .device_select_code, .input_width_strap, .primary_role_strap,
    .poll_mode_strap, .flag_chain_token_in, .flag_chain_token_out, .quad_status_flags,
    .almost_full_status_bus, .almost_full_status_bus_oe, .status_bus_sync,
    .write_queue_address, .write_address_en, .write_select, .write_queue_index,
    .read_queue_address, .read_address_en, .null_queue_select, .read_select,
    .read_null_select, .read_queue_index, .output_enable_n, .read_data_in,
    .read_data_out, .read_data_oe, .input_is_9bit, .is_primary, .poll_mode
  );

  mqe_ring_peer #(.DELAY(3)) peer (
    .ref_clk, .rst_n, .token_from_dev(flag_chain_token_out),
    .token_to_dev(peer_token)
  );

  // A single device closes the ring on itself; otherwise the peer stands for the others.
  assign flag_chain_token_in = self_loop ? flag_chain_token_out : peer_token;

  // Free-running 50 MHz clock.
  initial begin
    ref_clk = 1'b0;
    forever begin
      #10 ref_clk = ~ref_clk;
    end
  end

  // Cuts a hang short after far more cycles than the tests need.
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      give_verdict();
    end
  end

  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  task automatic give_verdict();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : give_verdict

  // Holds reset 20 cycles with the given straps, then releases it.
  task automatic do_reset(input logic [2:0] id, input logic iw, input logic pri,
                          input logic poll);
    @(posedge ref_clk);
    rst_n              <= 1'b0;
    device_select_code <= id;
    input_width_strap  <= iw;
    primary_role_strap <= pri;
    poll_mode_strap    <= poll;
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
  endtask : do_reset

  // One selection request, then returns at the negedge where the answer stands.
  task automatic sel(input logic rd, input logic [7:0] addr, input logic nul);
    @(posedge ref_clk);
    write_address_en    <= !rd;
    read_address_en     <= rd;
    write_queue_address <= addr;
    read_queue_address  <= addr;
    null_queue_select   <= nul;
    @(posedge ref_clk);
    write_address_en  <= 1'b0;
    read_address_en   <= 1'b0;
    null_queue_select <= 1'b0;
    @(negedge ref_clk);
  endtask : sel

  // Waits for quadrant 1, then checks the four quadrants in turn.
  task automatic ring();
    int n;
    n = 0;
    while (status_bus_sync !== 1'b1 && n < 40) begin
      @(negedge ref_clk);
      n++;
    end
    for (int k = 0; k < 4; k++) begin
      chk("status bus", FLAGS[8*k +: 8], almost_full_status_bus);
      chk("sync", k == 0, status_bus_sync);
      chk("token out", k == 3, flag_chain_token_out);
      chk("bus oe", 1, almost_full_status_bus_oe);
      @(negedge ref_clk);
    end
  endtask : ring

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial begin
    int n;
    rst_n = 1'b0;
    self_loop = 1'b0;
    {input_width_strap, primary_role_strap, poll_mode_strap} = 3'h0;
    {write_address_en, read_address_en, null_queue_select} = 3'h0;
    device_select_code = 3'h0;
    write_queue_address = 8'h00;
    read_queue_address = 8'h00;
    quad_status_flags = FLAGS;
    output_enable_n = 1'b1;
    read_data_in = 18'h00000;
    // Master with identity 5; the straps move right after release.
    do_reset(3'h5, 1'b1, 1'b1, 1'b1);
    device_select_code <= 3'h0;
    {input_width_strap, primary_role_strap, poll_mode_strap} <= 3'h0;
    ring();
    chk("idle bus oe", 0, almost_full_status_bus_oe);
    chk("9 bit", 1, input_is_9bit);
    chk("primary", 1, is_primary);
    chk("poll", 1, poll_mode);
    n = 0;
    while (flag_chain_token_in !== 1'b1 && n < 20) begin
      @(negedge ref_clk);
      n++;
    end
    @(negedge ref_clk);
    chk("sync after token", 1, status_bus_sync);
    // Queue selections against the captured identity.
    sel(1'b0, 8'hb3, 1'b0);
    chk("write select", 1, write_select);
    chk("write index", 5'h13, write_queue_index);
    sel(1'b0, 8'h14, 1'b0);
    chk("write select", 0, write_select);
    chk("write index", 5'h13, write_queue_index);
    sel(1'b1, 8'ha7, 1'b0);
    chk("read select", 1, read_select);
    chk("read index", 5'h07, read_queue_index);
    sel(1'b1, 8'ha2, 1'b1);
    chk("null select", 1, read_null_select);
    chk("read select", 0, read_select);
    // Master read bus follows the enable at once; data lags one cycle.
    @(posedge ref_clk);
    output_enable_n <= 1'b0;
    read_data_in    <= 18'h2a5a5;
    #2 chk("read oe", 1, read_data_oe);
    @(posedge ref_clk);
    output_enable_n <= 1'b1;
    #2 chk("read oe", 0, read_data_oe);
    chk("read data", 18'h2a5a5, read_data_out);
    // Slave with identity 2 stays off the shared buses until selected.
    do_reset(3'h2, 1'b0, 1'b0, 1'b1);
    output_enable_n <= 1'b0;
    for (int i = 0; i < 12; i++) begin
      @(negedge ref_clk);
      chk("slave bus oe", 0, almost_full_status_bus_oe);
    end
    chk("slave read oe", 0, read_data_oe);
    chk("18 bit", 0, input_is_9bit);
    chk("primary", 0, is_primary);
    sel(1'b1, 8'h61, 1'b0);
    chk("slave read oe", 0, read_data_oe);
    sel(1'b1, 8'h41, 1'b0);
    chk("slave read oe", 1, read_data_oe);
    @(posedge ref_clk);
    output_enable_n <= 1'b1;
    #2 chk("slave read oe", 0, read_data_oe);
    // Single master in direct mode leaves the status ring idle.
    do_reset(3'h0, 1'b0, 1'b1, 1'b0);
    repeat (6) @(negedge ref_clk);
    chk("poll", 0, poll_mode);
    chk("primary", 1, is_primary);
    chk("direct bus oe", 0, almost_full_status_bus_oe);
    // Single master in polled mode loops its own token and wraps to quadrant 1.
    self_loop <= 1'b1;
    do_reset(3'h0, 1'b0, 1'b1, 1'b1);
    ring();
    chk("wrap sync", 1, status_bus_sync);
    sel(1'b0, 8'h05, 1'b0);
    chk("write select", 1, write_select);
    chk("write index", 5'h05, write_queue_index);
    give_verdict();
  end
endmodule : test_mqe_config
